//--- verilog/pes_event_select.sv
// Event selection, counting and front-end redirect stall for one performance counter.
// Assumes event strobes are one-cycle pulses synchronous to ref_clk.
// What this block does
// - Scalar double arithmetic counted, loads/stores/logicals excluded.
// - Count loads missing first level, hitting second.
// - Count retired loads missing second-level cache.
// - Count translation-miss loads unless load faulted.
// - Count vector assists after vector state clear.
// - Assists include denormal and underflow cases.
// - Count every retired vector instruction.
// - Count only saturating retired vector instructions.
// - Count decoded branches, retired or not.
// - Count byte sequences falsely seen as taken branches.
// - False branch raises redirect, flushes target buffer.
// - Count every front-end redirect.
// - Each redirect stalls front end seven cycles.
`timescale 1ns/10ps
module pes_event_select #(
  parameter int STALL_CYCLES = pes_pkg::REDIRECT_STALL_CYCLES
) (
  input  wire logic                         ref_clk,
  input  wire logic                         reset,
  input  wire logic [7:0]                   eventCode,
  input  wire logic [7:0]                   unitMask,
  input  wire logic                         simdRetired,
  input  wire logic                         simdScalarDouble,
  input  wire logic                         simdArith,
  input  wire logic                         simdSaturating,
  input  wire logic                         loadRetired,
  input  wire logic                         loadL1Miss,
  input  wire logic                         loadL2Miss,
  input  wire logic                         loadTlbMiss,
  input  wire logic                         loadFault,
  input  wire logic                         vectorStateClearInstr,
  input  wire logic                         packedStateDirty,
  input  wire logic                         denormInput,
  input  wire logic                         denormalsAsZeroFlag,
  input  wire logic                         underflowResult,
  input  wire logic                         flushToZeroFlag,
  input  wire logic                         branchDecoded,
  input  wire logic                         falseBranchDetect,
  input  wire logic                         lateRedirect,
  output logic                              frontEndRedirectEvent,
  output logic                              branchTargetBufferFlush,
  output logic                              frontEndStall,
  output logic                              selectMatch,
  output logic [pes_pkg::CNT_WIDTH-1:0]     eventCount
);
  // The stall counter is eight bits wide, so a longer penalty cannot be held.
  if (STALL_CYCLES < 1 || STALL_CYCLES > 255) begin : g_bad_stall
    $error("STALL_CYCLES out of range");
  end

  logic simdArithRetiredEvent, loadSecondLevelHitEvent, loadSecondLevelMissEvent;
  logic loadTranslationMissEvent, vectorAssistEvent, vectorRetiredEvent;
  logic saturatingVectorRetiredEvent, branchDecodedEvent, falseBranchEvent;
  logic inc;

  always_comb begin
    simdArithRetiredEvent        = simdRetired & simdScalarDouble & simdArith;
    loadSecondLevelHitEvent      = loadRetired & loadL1Miss & ~loadL2Miss;
    loadSecondLevelMissEvent     = loadRetired & loadL2Miss;
    loadTranslationMissEvent     = loadRetired & loadTlbMiss & ~loadFault;
    vectorAssistEvent            = (vectorStateClearInstr & packedStateDirty)
                                 | (denormInput & ~denormalsAsZeroFlag)
                                 | (underflowResult & ~flushToZeroFlag);
    vectorRetiredEvent           = simdRetired;
    saturatingVectorRetiredEvent = simdRetired & simdSaturating;
    branchDecodedEvent           = branchDecoded;
    falseBranchEvent             = falseBranchDetect;
    frontEndRedirectEvent        = falseBranchDetect | lateRedirect;
    branchTargetBufferFlush      = falseBranchDetect;
  end

  always_comb begin
    selectMatch = 1'b1;
    inc         = 1'b0;
    case (eventCode)
      pes_pkg::EVT_SIMD_ARITH: begin
        selectMatch = (unitMask == pes_pkg::MASK_SCALAR_DBL);
        inc         = simdArithRetiredEvent;
      end
      pes_pkg::EVT_LOAD_RETIRED: begin
        case (unitMask)
          pes_pkg::MASK_L2_HIT:    inc = loadSecondLevelHitEvent;
          pes_pkg::MASK_L2_MISS:   inc = loadSecondLevelMissEvent;
          pes_pkg::MASK_DTLB_MISS: inc = loadTranslationMissEvent;
          default:                 selectMatch = 1'b0;
        endcase
      end
      pes_pkg::EVT_VEC_ASSIST: begin
        selectMatch = (unitMask == pes_pkg::MASK_NONE);
        inc         = vectorAssistEvent;
      end
      pes_pkg::EVT_VEC_RETIRED: begin
        selectMatch = (unitMask == pes_pkg::MASK_NONE);
        inc         = vectorRetiredEvent;
      end
      pes_pkg::EVT_SAT_RETIRED: begin
        selectMatch = (unitMask == pes_pkg::MASK_NONE);
        inc         = saturatingVectorRetiredEvent;
      end
      pes_pkg::EVT_BR_DECODED: begin
        selectMatch = (unitMask == pes_pkg::MASK_ONE);
        inc         = branchDecodedEvent;
      end
      pes_pkg::EVT_FALSE_BR: begin
        selectMatch = (unitMask == pes_pkg::MASK_ONE);
        inc         = falseBranchEvent;
      end
      pes_pkg::EVT_REDIRECT: begin
        selectMatch = (unitMask == pes_pkg::MASK_ONE);
        inc         = frontEndRedirectEvent;
      end
      default: selectMatch = 1'b0;
    endcase
  end

  logic [pes_pkg::CNT_WIDTH-1:0] count_ff, nxt_count;
  logic [7:0]                    stall_ff, nxt_stall;

  always_comb begin
    nxt_count = count_ff;
    if (selectMatch && inc) begin
      nxt_count = count_ff + 1'b1;
    end
    // A redirect during a stall restarts the full penalty.
    nxt_stall = (stall_ff != 8'h00) ? stall_ff - 8'h01 : 8'h00;
    if (frontEndRedirectEvent) begin
      nxt_stall = 8'(STALL_CYCLES);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      count_ff <= '0;
      stall_ff <= 8'h00;
    end else begin
      count_ff <= nxt_count;
      stall_ff <= nxt_stall;
    end
  end

  assign eventCount    = count_ff;
  assign frontEndStall = (stall_ff != 8'h00);

  a_count_gated: assert property (@(posedge ref_clk) disable iff (reset)
    !(selectMatch && inc) |=> (eventCount == $past(eventCount)))
    else $error("Count moved without a matching event");
  a_count_step: assert property (@(posedge ref_clk) disable iff (reset)
    (selectMatch && inc) |=> (eventCount == $past(eventCount) + 1'b1))
    else $error("Count did not step by one");
  a_tlb_fault: assert property (@(posedge ref_clk) disable iff (reset)
    (eventCode == pes_pkg::EVT_LOAD_RETIRED && unitMask == pes_pkg::MASK_DTLB_MISS && loadFault)
    |=> (eventCount == $past(eventCount)))
    else $error("Faulting load counted as translation miss");
  a_false_flush: assert property (@(posedge ref_clk) disable iff (reset)
    falseBranchDetect |-> (frontEndRedirectEvent && branchTargetBufferFlush))
    else $error("False branch without redirect and flush");
  // The repetition counts below assume the default penalty; other lengths skip these two checks.
  if (STALL_CYCLES == pes_pkg::REDIRECT_STALL_CYCLES) begin : g_stall_checks
    sequence s_redirect;
      frontEndRedirectEvent;
    endsequence
    sequence s_quiet;
      !frontEndRedirectEvent [*7];
    endsequence
    a_stall_len: assert property (@(posedge ref_clk) disable iff (reset)
      s_redirect ##1 s_quiet |=> ($past(frontEndStall, 1) && !frontEndStall))
      else $error("Redirect stall length wrong");
    a_stall_start: assert property (@(posedge ref_clk) disable iff (reset)
      frontEndRedirectEvent |=> frontEndStall [*7])
      else $error("Stall dropped early");
  end
  a_l2_hit: assert property (@(posedge ref_clk) disable iff (reset)
    (eventCode == pes_pkg::EVT_LOAD_RETIRED && unitMask == pes_pkg::MASK_L2_HIT
     && loadRetired && loadL1Miss && !loadL2Miss) |=> (eventCount == $past(eventCount) + 1'b1))
    else $error("Second level hit not counted");
  a_unmatched: assert property (@(posedge ref_clk) disable iff (reset)
    (eventCode == pes_pkg::EVT_VEC_RETIRED && unitMask != pes_pkg::MASK_NONE) |-> !selectMatch)
    else $error("Bad mask accepted");
  // Each selected row must step the counter on its own qualifying event and on nothing else.
  a_scalar_logic: assert property (@(posedge ref_clk) disable iff (reset)
    (eventCode == pes_pkg::EVT_SIMD_ARITH && unitMask == pes_pkg::MASK_SCALAR_DBL
     && simdRetired && !simdArith) |=> (eventCount == $past(eventCount)))
    else $error("Non-arithmetic scalar instruction counted");
  a_scalar_arith: assert property (@(posedge ref_clk) disable iff (reset)
    (eventCode == pes_pkg::EVT_SIMD_ARITH && unitMask == pes_pkg::MASK_SCALAR_DBL
     && simdRetired && simdScalarDouble && simdArith) |=> (eventCount == $past(eventCount) + 1'b1))
    else $error("Scalar double arithmetic not counted");
  a_l2_miss: assert property (@(posedge ref_clk) disable iff (reset)
    (eventCode == pes_pkg::EVT_LOAD_RETIRED && unitMask == pes_pkg::MASK_L2_MISS
     && loadRetired && loadL2Miss) |=> (eventCount == $past(eventCount) + 1'b1))
    else $error("Second level miss not counted");
  a_assist_clear: assert property (@(posedge ref_clk) disable iff (reset)
    (eventCode == pes_pkg::EVT_VEC_ASSIST && unitMask == pes_pkg::MASK_NONE
     && vectorStateClearInstr && packedStateDirty) |=> (eventCount == $past(eventCount) + 1'b1))
    else $error("State clear assist not counted");
  a_assist_denorm: assert property (@(posedge ref_clk) disable iff (reset)
    (eventCode == pes_pkg::EVT_VEC_ASSIST && unitMask == pes_pkg::MASK_NONE
     && denormInput && !denormalsAsZeroFlag) |=> (eventCount == $past(eventCount) + 1'b1))
    else $error("Denormal assist not counted");
  a_assist_underflow: assert property (@(posedge ref_clk) disable iff (reset)
    (eventCode == pes_pkg::EVT_VEC_ASSIST && unitMask == pes_pkg::MASK_NONE
     && underflowResult && !flushToZeroFlag) |=> (eventCount == $past(eventCount) + 1'b1))
    else $error("Underflow assist not counted");
  a_vec_retired: assert property (@(posedge ref_clk) disable iff (reset)
    (eventCode == pes_pkg::EVT_VEC_RETIRED && unitMask == pes_pkg::MASK_NONE
     && simdRetired) |=> (eventCount == $past(eventCount) + 1'b1))
    else $error("Retired vector instruction not counted");
  a_sat_only: assert property (@(posedge ref_clk) disable iff (reset)
    (eventCode == pes_pkg::EVT_SAT_RETIRED && unitMask == pes_pkg::MASK_NONE
     && simdRetired && !simdSaturating) |=> (eventCount == $past(eventCount)))
    else $error("Non-saturating instruction counted");
  a_branch_dec: assert property (@(posedge ref_clk) disable iff (reset)
    (eventCode == pes_pkg::EVT_BR_DECODED && unitMask == pes_pkg::MASK_ONE
     && branchDecoded) |=> (eventCount == $past(eventCount) + 1'b1))
    else $error("Decoded branch not counted");
  a_false_count: assert property (@(posedge ref_clk) disable iff (reset)
    (eventCode == pes_pkg::EVT_FALSE_BR && unitMask == pes_pkg::MASK_ONE
     && falseBranchDetect) |=> (eventCount == $past(eventCount) + 1'b1))
    else $error("False branch not counted");
  a_redirect_count: assert property (@(posedge ref_clk) disable iff (reset)
    (eventCode == pes_pkg::EVT_REDIRECT && unitMask == pes_pkg::MASK_ONE
     && lateRedirect) |=> (eventCount == $past(eventCount) + 1'b1))
    else $error("Front-end redirect not counted");
  a_flush_only: assert property (@(posedge ref_clk) disable iff (reset)
    branchTargetBufferFlush |-> falseBranchDetect)
    else $error("Target buffer flushed without a false branch");
endmodule // pes_event_select

//--- verilog/pes_pkg.sv
// Package for the performance event select decoder.
// Assumes one core clock domain; software programs the event code and unit mask.
package pes_pkg;
  localparam logic [7:0] EVT_SIMD_ARITH   = 8'hca;
  localparam logic [7:0] EVT_LOAD_RETIRED = 8'hcb;
  localparam logic [7:0] EVT_VEC_ASSIST   = 8'hcd;
  localparam logic [7:0] EVT_VEC_RETIRED  = 8'hce;
  localparam logic [7:0] EVT_SAT_RETIRED  = 8'hcf;
  localparam logic [7:0] EVT_BR_DECODED   = 8'he0;
  localparam logic [7:0] EVT_FALSE_BR     = 8'he4;
  localparam logic [7:0] EVT_REDIRECT     = 8'he6;

  localparam logic [7:0] MASK_NONE        = 8'h00;
  localparam logic [7:0] MASK_SCALAR_DBL  = 8'h08;
  localparam logic [7:0] MASK_L2_HIT      = 8'h01;
  localparam logic [7:0] MASK_L2_MISS     = 8'h02;
  localparam logic [7:0] MASK_DTLB_MISS   = 8'h04;
  localparam logic [7:0] MASK_ONE         = 8'h01;

  localparam int REDIRECT_STALL_CYCLES = 7;
  localparam int CNT_WIDTH             = 32;
endpackage : pes_pkg

//--- bench/pes_pipe_model.sv
// Pipeline event source model: expands a kind number into strobe and qualifier levels.
// Assumes the bench changes kind and fire just after the falling edge of the clock.
`timescale 1ns/10ps
module pes_pipe_model (
  input  wire logic [3:0]  kind,
  input  wire logic        fire,
  output logic      [17:0] strobes
);
  // Levels drop to zero whenever fire is low, so no stale qualifier can leak into a later count.
  always_comb begin
    strobes = 18'h00000;
    if (fire) begin
      case (kind)
        4'h0:    strobes = 18'h38000;
        4'h1:    strobes = 18'h20000;
        4'h2:    strobes = 18'h24000;
        4'h3:    strobes = 18'h03000;
        4'h4:    strobes = 18'h03800;
        4'h5:    strobes = 18'h02400;
        4'h6:    strobes = 18'h02600;
        4'h7:    strobes = 18'h00180;
        4'h8:    strobes = 18'h00040;
        4'h9:    strobes = 18'h00060;
        4'ha:    strobes = 18'h00010;
        4'hb:    strobes = 18'h00004;
        4'hc:    strobes = 18'h00002;
        4'hd:    strobes = 18'h00001;
        4'he:    strobes = 18'h30000;
        default: strobes = 18'h00000;
      endcase
    end
  end
endmodule // pes_pipe_model

//--- bench/pes_event_select_bench.sv
// Self-checking bench for the event select decoder: a row table, then redirect and reset cases.
// Assumes the pipeline model drives all event inputs and the stall length keeps its default.
`timescale 1ns/10ps
module pes_event_select_bench;
  logic        ref_clk = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  eventCode = 8'h00;
  logic [7:0]  unitMask = 8'h00;
  logic [3:0]  kind = 4'h0;
  logic        fire = 1'b0;
  logic [17:0] s;
  logic        redir, flush, stall, match;
  logic [31:0] cnt, base;
  int          fails = 0;
  int          samples_checked = 0;
  // Each row: code, mask, event kind, expected increment, expected match.
  logic [21:0] rows [26] = '{
    {8'hca, 8'h08, 4'h0, 2'h3}, {8'hca, 8'h08, 4'he, 2'h1}, {8'hca, 8'h08, 4'h1, 2'h1},
    {8'hcb, 8'h01, 4'h3, 2'h3}, {8'hcb, 8'h01, 4'h4, 2'h1}, {8'hcb, 8'h02, 4'h4, 2'h3},
    {8'hcb, 8'h02, 4'h3, 2'h1}, {8'hcb, 8'h04, 4'h5, 2'h3}, {8'hcb, 8'h04, 4'h6, 2'h1},
    {8'hcd, 8'h00, 4'h7, 2'h3}, {8'hcd, 8'h00, 4'h8, 2'h3}, {8'hcd, 8'h00, 4'h9, 2'h1},
    {8'hcd, 8'h00, 4'ha, 2'h3}, {8'hce, 8'h00, 4'h1, 2'h3}, {8'hce, 8'h00, 4'h2, 2'h3},
    {8'hcf, 8'h00, 4'h2, 2'h3}, {8'hcf, 8'h00, 4'h1, 2'h1}, {8'he0, 8'h01, 4'hb, 2'h3},
    {8'he4, 8'h01, 4'hc, 2'h3}, {8'he6, 8'h01, 4'hd, 2'h3}, {8'he6, 8'h01, 4'hc, 2'h3},
    {8'hce, 8'h01, 4'h1, 2'h0}, {8'he0, 8'h00, 4'hb, 2'h0}, {8'hcb, 8'h08, 4'h3, 2'h0},
    {8'h00, 8'h00, 4'h1, 2'h0}, {8'hca, 8'h00, 4'h0, 2'h0}};
  always #50 ref_clk = ~ref_clk;
  pes_pipe_model partner (.kind(kind), .fire(fire), .strobes(s));
  pes_event_select dut (.ref_clk(ref_clk), .reset(reset), .eventCode(eventCode), .unitMask(unitMask),
    .simdRetired(s[17]), .simdScalarDouble(s[16]), .simdArith(s[15]), .simdSaturating(s[14]),
    .loadRetired(s[13]), .loadL1Miss(s[12]), .loadL2Miss(s[11]), .loadTlbMiss(s[10]), .loadFault(s[9]),
    .vectorStateClearInstr(s[8]), .packedStateDirty(s[7]), .denormInput(s[6]), .denormalsAsZeroFlag(s[5]),
    .underflowResult(s[4]), .flushToZeroFlag(s[3]), .branchDecoded(s[2]), .falseBranchDetect(s[1]),
    .lateRedirect(s[0]), .frontEndRedirectEvent(redir), .branchTargetBufferFlush(flush),
    .frontEndStall(stall), .selectMatch(match), .eventCount(cnt));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic pulse(input logic [3:0] k);
    @(negedge ref_clk);
    kind = k;
    fire = 1'b1;
    #1;
  endtask
  task automatic stop();
    @(negedge ref_clk);
    fire = 1'b0;
  endtask
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #50000;
    fails++;
    end_sim();
  end
  initial begin
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk);
    reset = 1'b0;
    chk({31'h0, stall}, 32'h0);
    chk(cnt, 32'h0);
    foreach (rows[i]) begin
      eventCode = rows[i][21:14];
      unitMask = rows[i][13:6];
      base = cnt;
      pulse(rows[i][5:2]);
      chk({31'h0, match}, {31'h0, rows[i][0]});
      stop();
      chk(cnt, base + {31'h0, rows[i][1]});
    end
    // Back-to-back events must each count once.
    eventCode = 8'hce;
    base = cnt;
    pulse(4'h1);
    pulse(4'h2);
    stop();
    chk(cnt, base + 32'h2);
    pulse(4'hd);
    chk({30'h0, redir, flush}, 32'h2);
    pulse(4'hc);
    chk({30'h0, redir, flush}, 32'h3);
    stop();
    for (int i = 0; i < 7; i++) begin
      chk({31'h0, stall}, 32'h1);
      @(negedge ref_clk);
    end
    chk({31'h0, stall}, 32'h0);
    // A reset in the middle of a stall must clear the stall as well as the count.
    pulse(4'hd);
    stop();
    chk({31'h0, stall}, 32'h1);
    reset = 1'b1;
    @(negedge ref_clk);
    reset = 1'b0;
    chk(cnt, 32'h0);
    chk({31'h0, stall}, 32'h0);
    end_sim();
  end
endmodule // pes_event_select_bench
